/* File: inc/flash_self_program_pkg.sv */
// Constants and types shared by the flash self-programming control block
package flash_self_program_pkg;
    // Clock and programming time
    localparam int CLK_PERIOD_NS = 10;
    localparam int OP_TIME_NS = 4_500_000;
    localparam int OP_CYCLES = OP_TIME_NS / CLK_PERIOD_NS;
    localparam int OP_CNT_W = 20;
    // Command windows, in cycles after the control write
    localparam logic [2:0] SPM_WINDOW = 3'h4;
    localparam logic [2:0] LPM_WINDOW = 3'h3;
    localparam logic [2:0] WIN_LAST = 3'h1;
    // Control/status bit positions
    localparam int CTRL_IRQ_EN = 7;
    localparam int CTRL_RWW_BUSY = 6;
    localparam int CTRL_REENABLE = 4;
    localparam int CTRL_LOCK_SEL = 3;
    localparam int CTRL_PROG_EN = 0;
    localparam int CMD_W = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Command patterns in the low five bits
    localparam logic [4:0] CMD_NONE = 5'h00;
    localparam logic [4:0] CMD_REENABLE = 5'h11;
    localparam logic [4:0] CMD_LOCK = 5'h09;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_LOAD = 5'h01;
    // Address pointer fields
    localparam int WORD_LSB = 1;
    localparam int WORD_MSB = 6;
    localparam int PAGE_LSB = 7;
    localparam int PAGE_MSB = 13;
    localparam int WORD_W = 6;
    localparam int PAGE_W = 7;
    localparam logic [6:0] RWW_PAGE_LIMIT = 7'h60;
    // Fuse and lock read pointers
    localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
    localparam logic [15:0] PTR_LOCK = 16'h0001;
    localparam logic [15:0] PTR_EXT_FUSE = 16'h0002;
    localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
    // Lock byte layout
    localparam logic [7:0] LOCK_RESET = 8'hFF;
    localparam int LOCK_BOOT_LSB = 2;
    localparam int LOCK_BOOT_MSB = 5;
    localparam logic [3:0] EXT_UNUSED = 4'hF;
    // Long operation in progress
    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_ERASE = 2'b01,
        OP_WRITE = 2'b10,
        OP_LOCK = 2'b11
    } op_type;
endpackage

/* File: verilog/cmd_window.sv */
// Countdown that opens the store and load windows after a control write
`timescale 1ns/1ps
`default_nettype none
module cmd_window
    import flash_self_program_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Control
    input wire logic start_i,
    input wire logic stop_i,
    // Window state
    output logic spm_open_o,
    output logic lpm_open_o,
    output logic expire_o
);
    logic [2:0] cnt_r; // Cycles left in the store window
    logic [2:0] cnt_nxt;

    // Load fraction of the store window still open for loads
    assign spm_open_o = (cnt_r != 3'h0);
    assign lpm_open_o = (cnt_r > (SPM_WINDOW - LPM_WINDOW));
    assign expire_o = (cnt_r == WIN_LAST);
    assign cnt_nxt = start_i ? SPM_WINDOW : (stop_i ? 3'h0 :
                     (spm_open_o ? cnt_r - WIN_LAST : 3'h0));

    // Window counter
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= 3'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/op_timer.sv */
// Timer for the duration of an erase, write or lock programming step
`timescale 1ns/1ps
`default_nettype none
module op_timer
    import flash_self_program_pkg::*;
#(
    parameter int CYCLES = OP_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Control
    input wire logic start_i,
    // Completion pulse
    output logic done_o
);
    localparam logic [OP_CNT_W-1:0] LOAD = OP_CNT_W'(CYCLES);
    localparam logic [OP_CNT_W-1:0] ONE = OP_CNT_W'(1);
    logic [OP_CNT_W-1:0] cnt_r; // Cycles left
    logic [OP_CNT_W-1:0] cnt_nxt;

    assign done_o = (cnt_r == ONE);
    assign cnt_nxt = start_i ? LOAD : ((cnt_r != '0) ? cnt_r - ONE : cnt_r);

    // Down counter
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/flash_self_program_control.sv */
// Self-programming control: command windows, flash operations, fuse reads
//
// Notes on behaviour
// - Write pattern plus store in four cycles
// - Write page comes from page field only
// - Write to non-READ_WHILE_WRITE_AREA area halts core
// - Interrupt asserted while enable bit cleared
// - READ_WHILE_WRITE_AREA reads blocked, busy flag while programming
// - Lock pattern plus store sets lock bits
// - Zero lock data bits 5..2 program locks
// - Lock programming blocks no flash area
// - EEPROM write blocks commands and fuse reads
// - Lock read: pointer one, load within three
// - Lock select and enable auto clear
// - Cleared bits make load an ordinary read
// - Pointer zero returns fuse low byte
// - Pointer three returns fuse high byte
// - Pointer two returns extended fuse nibble
// - Programmed bits read zero, unprogrammed one
// - Erase pattern plus store erases page
// - Load pattern plus store fills buffer word
// - Enable clears after store (erase, write, lock: at step end) or window end
// - Unknown command patterns have no effect
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_control
    import flash_self_program_pkg::*;
#(
    parameter int OP_CYCLES_P = OP_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Control register write from the core
    input wire logic ctrl_wr_i,
    input wire logic [7:0] ctrl_wdata_i,
    // Instruction strobes and operands from the core
    input wire logic store_prog_i,
    input wire logic load_prog_i,
    input wire logic [15:0] addr_ptr_i,
    input wire logic [7:0] data_low_i,
    input wire logic [7:0] data_high_i,
    // EEPROM state and stored fuse bytes
    input wire logic eeprom_write_pending_i,
    input wire logic [7:0] fuse_low_value_i,
    input wire logic [7:0] fuse_high_value_i,
    input wire logic [3:0] extended_fuse_value_i,
    // Control/status readback and interrupt
    output logic [7:0] ctrl_rdata_o,
    output logic spm_irq_o,
    // Core side effects
    output logic cpu_halt_o,
    output logic rww_read_block_o,
    output logic lpm_valid_o,
    output logic [7:0] lpm_data_o,
    // Temporary buffer and flash array
    output logic buf_load_o,
    output logic [WORD_W-1:0] buf_word_o,
    output logic [15:0] buf_data_o,
    output logic buf_clear_o,
    output logic flash_erase_o,
    output logic flash_write_o,
    output logic [PAGE_W-1:0] flash_page_o,
    output logic [7:0] lock_bits_o
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0] ctrl_r; // Control/status register
    logic [7:0] ctrl_nxt;
    op_type op_state_r; // Long operation state
    op_type op_state_nxt;
    logic [7:0] lock_r; // Lock byte, one means unprogrammed
    logic [7:0] lock_nxt;
    logic spm_open; // Store window open
    logic lpm_open; // Load window open
    logic win_expire; // Last window cycle
    logic op_done; // Operation finished
    logic [4:0] cmd_code; // Written command pattern
    logic [4:0] cur_cmd; // Armed command pattern
    logic cmd_known; // Pattern is defined
    logic busy; // Erase, write or lock running
    logic armed; // Enable set and nothing running
    logic ctrl_take; // Command write accepted
    logic spm_take; // Store instruction accepted
    logic lpm_take; // Fuse or lock read accepted
    logic long_op; // Store starts a timed step
    logic [PAGE_W-1:0] ptr_page; // Page field of the pointer
    logic ptr_rww; // Page lies in the READ_WHILE_WRITE_AREA area
    logic [7:0] read_byte; // Selected fuse or lock byte

    ////////////////////////////////////////////////////////////////////////
    // Decode
    // Known patterns only
    function automatic logic is_known(input logic [4:0] code);
        is_known = (code == CMD_REENABLE) || (code == CMD_LOCK) ||
                   (code == CMD_WRITE) || (code == CMD_ERASE) || (code == CMD_LOAD);
    endfunction

    assign cmd_code = ctrl_wdata_i[CMD_W-1:0];
    assign cur_cmd = ctrl_r[CMD_W-1:0];
    assign cmd_known = is_known(cmd_code);
    assign busy = (op_state_r != OP_IDLE);
    assign armed = ctrl_r[CTRL_PROG_EN] && !busy;
    assign ctrl_take = ctrl_wr_i && cmd_known && !busy && !eeprom_write_pending_i;
    assign spm_take = store_prog_i && armed && spm_open && !eeprom_write_pending_i;
    assign lpm_take = load_prog_i && armed && ctrl_r[CTRL_LOCK_SEL] && lpm_open &&
                      !eeprom_write_pending_i;
    assign long_op = spm_take && ((cur_cmd == CMD_ERASE) || (cur_cmd == CMD_WRITE) ||
                     (cur_cmd == CMD_LOCK));
    assign ptr_page = addr_ptr_i[PAGE_MSB:PAGE_LSB];
    assign ptr_rww = (ptr_page < RWW_PAGE_LIMIT);
    assign read_byte = (addr_ptr_i == PTR_FUSE_LOW) ? fuse_low_value_i :
                       (addr_ptr_i == PTR_FUSE_HIGH) ? fuse_high_value_i :
                       (addr_ptr_i == PTR_EXT_FUSE) ? {EXT_UNUSED, extended_fuse_value_i} :
                       lock_r;

    ////////////////////////////////////////////////////////////////////////
    // Window and timer
    cmd_window u_window (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .start_i(ctrl_take),
        .stop_i(spm_take || lpm_take),
        .spm_open_o(spm_open),
        .lpm_open_o(lpm_open),
        .expire_o(win_expire)
    );

    op_timer #(
        .CYCLES(OP_CYCLES_P)
    ) u_timer (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .start_i(long_op),
        .done_o(op_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control register next value
    always_comb begin
        ctrl_nxt = ctrl_r;
        // Interrupt enable is plain storage
        if (ctrl_wr_i) begin
            ctrl_nxt[CTRL_IRQ_EN] = ctrl_wdata_i[CTRL_IRQ_EN];
        end
        if (ctrl_take) begin
            ctrl_nxt[CMD_W-1:0] = cmd_code;
        end else if (win_expire && armed && !spm_take && !lpm_take) begin
            ctrl_nxt[CMD_W-1:0] = CMD_NONE;
        end
        if (spm_take && !long_op) begin
            ctrl_nxt[CMD_W-1:0] = CMD_NONE;
        end
        if (lpm_take) begin
            ctrl_nxt[CMD_W-1:0] = CMD_NONE;
        end
        // READ_WHILE_WRITE_AREA busy while that area programs
        if (long_op && (cur_cmd != CMD_LOCK) && ptr_rww) begin
            ctrl_nxt[CTRL_RWW_BUSY] = 1'b1;
        end
        // Re-enable clears the busy flag
        if (spm_take && (cur_cmd == CMD_REENABLE)) begin
            ctrl_nxt[CTRL_RWW_BUSY] = 1'b0;
        end
        // enable held until the step ends
        if (op_done && busy) begin
            ctrl_nxt[CMD_W-1:0] = CMD_NONE;
        end
    end

    // Operation state and lock byte next values
    assign op_state_nxt = (op_done && busy) ? OP_IDLE :
                          !long_op ? op_state_r :
                          (cur_cmd == CMD_ERASE) ? OP_ERASE :
                          (cur_cmd == CMD_WRITE) ? OP_WRITE : OP_LOCK;
    // zero data bits program boot locks
    assign lock_nxt = (spm_take && (cur_cmd == CMD_LOCK)) ?
        {lock_r[7:LOCK_BOOT_MSB+1],
         lock_r[LOCK_BOOT_MSB:LOCK_BOOT_LSB] & data_low_i[LOCK_BOOT_MSB:LOCK_BOOT_LSB],
         lock_r[LOCK_BOOT_LSB-1:0]} : lock_r;

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_r <= CTRL_RESET;
            op_state_r <= OP_IDLE;
            lock_r <= LOCK_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
            op_state_r <= op_state_nxt;
            lock_r <= lock_nxt;
        end
    end

    // Status outputs follow the next state
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_rdata_o <= CTRL_RESET;
            spm_irq_o <= 1'b0;
            cpu_halt_o <= 1'b0;
            rww_read_block_o <= 1'b0;
            lock_bits_o <= LOCK_RESET;
        end else begin
            ctrl_rdata_o <= ctrl_nxt;
            spm_irq_o <= ctrl_nxt[CTRL_IRQ_EN] && !ctrl_nxt[CTRL_PROG_EN];
            // halt only for the non-READ_WHILE_WRITE_AREA area
            if (long_op) begin
                cpu_halt_o <= (cur_cmd != CMD_LOCK) && !ptr_rww;
            end else if (op_done) begin
                cpu_halt_o <= 1'b0;
            end
            // block READ_WHILE_WRITE_AREA reads with the busy flag
            rww_read_block_o <= ctrl_nxt[CTRL_RWW_BUSY];
            lock_bits_o <= lock_nxt;
        end
    end

    // Command pulses toward the buffer, array and core
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            buf_load_o <= 1'b0;
            buf_word_o <= '0;
            buf_data_o <= 16'h0000;
            buf_clear_o <= 1'b0;
            flash_erase_o <= 1'b0;
            flash_write_o <= 1'b0;
            flash_page_o <= '0;
            lpm_valid_o <= 1'b0;
            lpm_data_o <= 8'h00;
        end else begin
            buf_load_o <= spm_take && (cur_cmd == CMD_LOAD);
            if (spm_take && (cur_cmd == CMD_LOAD)) begin
                buf_word_o <= addr_ptr_i[WORD_MSB:WORD_LSB];
                buf_data_o <= {data_high_i, data_low_i};
            end
            // Buffer empties after a write or on re-enable
            buf_clear_o <= (op_done && (op_state_r == OP_WRITE)) ||
                           (spm_take && (cur_cmd == CMD_REENABLE));
            flash_erase_o <= spm_take && (cur_cmd == CMD_ERASE);
            flash_write_o <= spm_take && (cur_cmd == CMD_WRITE);
            if (spm_take && ((cur_cmd == CMD_ERASE) || (cur_cmd == CMD_WRITE))) begin
                flash_page_o <= ptr_page;
            end
            // ordinary loads left to the core
            lpm_valid_o <= lpm_take;
            if (lpm_take) begin
                lpm_data_o <= read_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_write_start;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (spm_take && cur_cmd == CMD_WRITE) |=>
            flash_write_o && flash_page_o == $past(ptr_page) && ctrl_rdata_o[CTRL_PROG_EN];
    endproperty
    a_write_start: assert property (p_write_start) else $error("write not started");

    property p_halt_non_rww_area;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (long_op && cur_cmd == CMD_WRITE && !ptr_rww) |=> cpu_halt_o [*2];
    endproperty
    a_halt_non_rww_area: assert property (p_halt_non_rww_area) else $error("core not halted");

    property p_irq_level;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        spm_irq_o == (ctrl_rdata_o[CTRL_IRQ_EN] && !ctrl_rdata_o[CTRL_PROG_EN]);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

    property p_rww_busy;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (long_op && cur_cmd != CMD_LOCK && ptr_rww) |=>
            (rww_read_block_o && ctrl_rdata_o[CTRL_RWW_BUSY]) [*2];
    endproperty
    a_rww_busy: assert property (p_rww_busy) else $error("READ_WHILE_WRITE_AREA area not blocked");

    property p_lock_prog;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (spm_take && cur_cmd == CMD_LOCK) |=>
            lock_bits_o[LOCK_BOOT_MSB:LOCK_BOOT_LSB] ==
            $past(lock_r[LOCK_BOOT_MSB:LOCK_BOOT_LSB] & data_low_i[LOCK_BOOT_MSB:LOCK_BOOT_LSB]);
    endproperty
    a_lock_prog: assert property (p_lock_prog) else $error("lock bits wrong");

    property p_lock_free;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (op_state_r == OP_LOCK) |-> !cpu_halt_o;
    endproperty
    a_lock_free: assert property (p_lock_free) else $error("halt during lock set");

    property p_eeprom_block;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (eeprom_write_pending_i && (store_prog_i || load_prog_i)) |=>
            !flash_write_o && !flash_erase_o && !buf_load_o && !lpm_valid_o;
    endproperty
    a_eeprom_block: assert property (p_eeprom_block) else $error("EEPROM did not block");

    property p_lock_read;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (lpm_take && addr_ptr_i == PTR_LOCK) |=>
            lpm_valid_o && lpm_data_o == $past(lock_r) && !ctrl_rdata_o[CTRL_PROG_EN];
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock read wrong");

    property p_window_end;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        ctrl_take ##1 (!store_prog_i && !load_prog_i && !ctrl_wr_i) [*4] |=>
            !ctrl_rdata_o[CTRL_PROG_EN] && !ctrl_rdata_o[CTRL_LOCK_SEL];
    endproperty
    a_window_end: assert property (p_window_end) else $error("window did not close");

    property p_ext_fuse;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (lpm_take && addr_ptr_i == PTR_EXT_FUSE) |=>
            lpm_data_o == {EXT_UNUSED, $past(extended_fuse_value_i)};
    endproperty
    a_ext_fuse: assert property (p_ext_fuse) else $error("extended fuse wrong");

    c_page_write: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        spm_take && cur_cmd == CMD_WRITE);
    c_lock_read: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) lpm_take);
    c_op_done: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        op_done && busy);
endmodule
`default_nettype wire

/* File: testbench/core_model.sv */
// Processor core model issuing control writes and program instructions
`timescale 1ns/1ps
`default_nettype none
module core_model (
    // Clock
    input wire logic sys_clk_i,
    // Requests towards the block
    output logic ctrl_wr_o,
    output logic [7:0] ctrl_wdata_o,
    output logic store_prog_o,
    output logic load_prog_o,
    output logic [15:0] addr_ptr_o,
    output logic [7:0] data_low_o,
    output logic [7:0] data_high_o
);
    // model fetches no vectors
    // Idle core: no write, no instruction
    initial begin
        ctrl_wr_o = 1'b0;
        ctrl_wdata_o = 8'h00;
        store_prog_o = 1'b0;
        load_prog_o = 1'b0;
        addr_ptr_o = 16'h0000;
        {data_high_o, data_low_o} = 16'h0000;
    end
    // Control write, then a store or load gap cycles later (gap 0 sends none)
    // timed command window
    task automatic issue(input logic [7:0] ctrl, input logic [15:0] ptr,
                         input logic [15:0] data, input logic is_load, input int gap);
        @(posedge sys_clk_i);
        #1;
        addr_ptr_o = ptr;
        {data_high_o, data_low_o} = data;
        ctrl_wdata_o = ctrl;
        ctrl_wr_o = 1'b1;
        @(posedge sys_clk_i);
        #1;
        ctrl_wr_o = 1'b0;
        // Released write data no longer shows the old value
        ctrl_wdata_o = ~ctrl;
        if (gap > 0) begin
            repeat (gap - 1) begin
                @(posedge sys_clk_i);
                #1;
            end
            store_prog_o = !is_load;
            load_prog_o = is_load;
            @(posedge sys_clk_i);
            #1;
            store_prog_o = 1'b0;
            load_prog_o = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

/* File: testbench/flash_self_program_control_tb_top.sv */
// Self-checking bench for the flash self-programming control block
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_control_tb_top;
    import flash_self_program_pkg::*;
    localparam int OPS = 20;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic eeprom_write_pending_i = 1'b0;
    logic ctrl_wr, store_prog, load_prog;
    logic [7:0] ctrl_wdata, data_low, data_high;
    logic [15:0] addr_ptr;
    logic [7:0] ctrl_rdata_o, lpm_data_o, lock_bits_o;
    logic spm_irq_o, cpu_halt_o, rww_read_block_o, lpm_valid_o;
    logic buf_load_o, buf_clear_o, flash_erase_o, flash_write_o;
    logic [WORD_W-1:0] buf_word_o;
    logic [15:0] buf_data_o;
    logic [PAGE_W-1:0] flash_page_o;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [7:0] rd_exp [4];
    logic [7:0] bad_cmd [3];
    int bad_gap [3];
    always #5 sys_clk_i = ~sys_clk_i;
    core_model core (.sys_clk_i(sys_clk_i), .ctrl_wr_o(ctrl_wr), .ctrl_wdata_o(ctrl_wdata),
        .store_prog_o(store_prog), .load_prog_o(load_prog), .addr_ptr_o(addr_ptr),
        .data_low_o(data_low), .data_high_o(data_high));
    flash_self_program_control #(.OP_CYCLES_P(OPS)) uut (.sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i), .ctrl_wr_i(ctrl_wr), .ctrl_wdata_i(ctrl_wdata),
        .store_prog_i(store_prog), .load_prog_i(load_prog), .addr_ptr_i(addr_ptr),
        .data_low_i(data_low), .data_high_i(data_high),
        .eeprom_write_pending_i(eeprom_write_pending_i), .fuse_low_value_i(8'h62),
        .fuse_high_value_i(8'hD9), .extended_fuse_value_i(4'h9),
        .ctrl_rdata_o(ctrl_rdata_o), .spm_irq_o(spm_irq_o), .cpu_halt_o(cpu_halt_o),
        .rww_read_block_o(rww_read_block_o), .lpm_valid_o(lpm_valid_o),
        .lpm_data_o(lpm_data_o), .buf_load_o(buf_load_o), .buf_word_o(buf_word_o),
        .buf_data_o(buf_data_o), .buf_clear_o(buf_clear_o), .flash_erase_o(flash_erase_o),
        .flash_write_o(flash_write_o), .flash_page_o(flash_page_o), .lock_bits_o(lock_bits_o));
    // Compare one value and count it
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Step to the settled point after the answering edge
    task automatic step();
        @(posedge sys_clk_i);
        #1;
    endtask
    // Wait for the enable bit to drop, bounded
    task automatic wait_idle();
        int n;
        n = 0;
        while (ctrl_rdata_o[CTRL_PROG_EN] !== 1'b0 && n < 60) begin
            step();
            n++;
        end
        chk(n < 60, 1'b1);
    endtask
    // Counts and verdict, then stop
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Cycle ceiling against hangs
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            test_done();
        end
    end
    initial begin
        rd_exp = '{8'h62, 8'hC3, 8'hF9, 8'hD9};
        bad_cmd = '{8'h05, 8'h07, 8'h05};
        bad_gap = '{5, 1, 1};
        repeat (20) @(posedge sys_clk_i);
        #1;
        reset_n_i = 1'b1;
        chk(lock_bits_o, 16'h00FF);
        chk(ctrl_rdata_o, 16'h0000);
        $display("test reset done");
        core.issue(8'h01, 16'h000A, 16'hBEEF, 1'b0, 4);
        chk({buf_load_o, 9'h000, buf_word_o}, 16'h8005);
        chk(buf_data_o, 16'hBEEF);
        step();
        chk(ctrl_rdata_o[CMD_W-1:0], 16'h0000);
        $display("test buffer load done");
        core.issue(8'h85, 16'h0180, 16'h1234, 1'b0, 4);
        chk({flash_write_o, rww_read_block_o, cpu_halt_o, flash_page_o}, 16'h0303);
        chk(ctrl_rdata_o[CTRL_RWW_BUSY], 1'b1);
        chk({spm_irq_o, ctrl_rdata_o[CTRL_PROG_EN]}, 16'h0001);
        wait_idle();
        chk(buf_clear_o, 1'b1);
        step();
        chk({spm_irq_o, rww_read_block_o}, 16'h0003);
        core.issue(8'h11, 16'h0000, 16'h0000, 1'b0, 2);
        chk(buf_clear_o, 1'b1);
        step();
        step();
        chk({spm_irq_o, rww_read_block_o, ctrl_rdata_o[CTRL_RWW_BUSY]}, 16'h0000);
        $display("test page write done");
        core.issue(8'h03, 16'h3000, 16'h0000, 1'b0, 3);
        chk({flash_erase_o, rww_read_block_o, cpu_halt_o, flash_page_o}, 16'h02E0);
        wait_idle();
        step();
        chk(cpu_halt_o, 1'b0);
        $display("test page erase done");
        core.issue(8'h09, 16'h0001, 16'h00C3, 1'b0, 4);
        step();
        chk({lock_bits_o, cpu_halt_o, rww_read_block_o}, 16'h030C);
        wait_idle();
        $display("test lock set done");
        for (int i = 0; i < 4; i++) begin
            core.issue(8'h09, i[15:0], 16'h0000, 1'b1, 3);
            chk({lpm_valid_o, lpm_data_o}, {8'h01, rd_exp[i]});
            chk(ctrl_rdata_o[CTRL_LOCK_SEL], 1'b0);
        end
        core.issue(8'h09, 16'h0000, 16'h0000, 1'b1, 4);
        step();
        chk(lpm_valid_o, 1'b0);
        $display("test fuse reads done");
        for (int i = 0; i < 3; i++) begin
            eeprom_write_pending_i = (i == 2);
            core.issue(bad_cmd[i], 16'h0180, 16'h0000, 1'b0, bad_gap[i]);
            step();
            chk({flash_write_o, flash_erase_o, ctrl_rdata_o[CMD_W-1:0]}, 16'h0000);
        end
        core.issue(8'h09, 16'h0001, 16'h0000, 1'b1, 1);
        step();
        chk(lpm_valid_o, 1'b0);
        eeprom_write_pending_i = 1'b0;
        $display("test refusals done");
        test_done();
    end
endmodule
`default_nettype wire
